// ==== hdl/gauge_cfg_pkg.sv ====
// constants and carrier types for the gauge configuration, alert and command logic
// assumes a single clock domain and a serial engine that presents whole 16-bit words
package gauge_cfg_pkg;

	// ----------------------------------------
	// register map
	// ----------------------------------------
	localparam logic [7:0] GAUGE_SETTINGS_ADDR = 8'h0c;
	localparam logic [7:0] SPECIAL_COMMAND_ADDR = 8'hfe;
	localparam logic [15:0] FULL_RESET_CODE = 16'h0054;

	// ----------------------------------------
	// field layout of gauge_settings
	// ----------------------------------------
	localparam int COMP_LSB = 8;
	localparam int COMP_MSB = 15;
	localparam int SLEEP_BIT = 7;
	localparam int DONT_CARE_BIT = 6;
	localparam int FLAG_BIT = 5;
	localparam int LEVEL_MSB = 4;
	localparam int LEVEL_LSB = 0;

	// ----------------------------------------
	// reset values and threshold decode
	// ----------------------------------------
	localparam logic [7:0] COMP_RESET = 8'h97;
	localparam logic [4:0] LEVEL_RESET = 5'h1c;
	localparam logic DONT_CARE_READ = 1'b0;
	localparam logic [5:0] LEVEL_TOP_PCT = 6'h20;

	typedef struct packed {
		logic [7:0] model_compensation_byte;
		logic sleep;
		logic dont_care;
		logic low_charge_flag;
		logic [4:0] charge_alert_level;
	} settings_t;

	localparam settings_t SETTINGS_RESET = '{
		model_compensation_byte: COMP_RESET,
		sleep: 1'b0,
		dont_care: DONT_CARE_READ,
		low_charge_flag: 1'b0,
		charge_alert_level: LEVEL_RESET
	};

	typedef struct packed {
		logic en;
		logic [7:0] addr;
		logic [15:0] data;
	} reg_write_t;

endpackage

// ==== hdl/gauge_config_alert_control.sv ====
// configuration, low-charge alert and special command register logic of the gauge
// assumes the omitted serial engine raises i_wr_en once all 16 bits of a word are in,
// and that the state-of-charge source shares I_MCLK
// Notes on behaviour
// R1 - settings word: compensation 15:8, sleep 7, don't-care 6, flag 5, level 4:0
// R2 - writing sleep to one halts gauge work and enters low-power sleep
// R3 - writing sleep to zero leaves sleep and resumes gauge work
// R4 - sleep bit is zero after reset, so the gauge starts running
// R5 - don't-care bit reads a fixed value; writes to it do nothing
// R6 - charge below the alert level sets the flag and raises the interrupt
// R7 - flag stays set until software writes zero; hardware never clears it
// R8 - flag is zero after reset
// R9 - alert level is a five-bit field choosing the charge percentage
// R10 - alert percentage is thirty-two minus the code, one percent per step
// R11 - level field is a complemented count plus one, one percent per step
// R12 - alert level resets to code 1c, meaning four percent
// R13 - writing 0054 to the command register fully resets the device
// R14 - software writes only the reset code to the command register
// R15 - rising edge on the restart pin restarts gauge calculations
// R16 - alert pin is driven low while the flag is pending
// R17 - after clearing, a new alert needs charge to rise then fall again
// R18 - full reset acts when the last bit is in; that byte gets no ack
// R19 - entering sleep keeps a pending alert in the flag and on the pin
`timescale 1ns/1ns
module gauge_config_alert_control (
	// clock and reset
	input wire logic I_MCLK,
	input wire logic I_RESET_N,
	// register word port from the serial engine
	input wire logic I_WR_EN,
	input wire logic [7:0] I_WR_ADDR,
	input wire logic [15:0] I_WR_DATA,
	input wire logic [7:0] I_RD_ADDR,
	output logic [15:0] O_RD_DATA,
	output logic O_NO_ACK,
	// gauge core
	input wire logic I_SOC_VALID,
	input wire logic [7:0] I_SOC_PCT,
	output logic O_SLEEP,
	output logic O_RESTART,
	output logic O_FULL_RESET,
	output logic [7:0] O_COMPENSATION,
	// pins
	input wire logic I_FAST_RESTART_PIN,
	output logic O_LOW_CHARGE_OUT,
	output logic O_LOW_CHARGE_OE_N
);

	// ----------------------------------------
	// decoding
	// ----------------------------------------
	// percentage that a level code stands for
	function automatic logic [7:0] level_pct(input logic [4:0] code);
		level_pct = {2'b00, gauge_cfg_pkg::LEVEL_TOP_PCT - {1'b0, code}};
	endfunction

	gauge_cfg_pkg::settings_t settings;
	gauge_cfg_pkg::settings_t next_settings;
	gauge_cfg_pkg::reg_write_t wr;
	logic armed;
	logic next_armed;
	logic [2:0] pin_sync;
	logic pin_level;

	assign wr = '{en: I_WR_EN, addr: I_WR_ADDR, data: I_WR_DATA};

	wire settings_wr = wr.en && (wr.addr == gauge_cfg_pkg::GAUGE_SETTINGS_ADDR);
	wire full_reset_wr = wr.en && (wr.addr == gauge_cfg_pkg::SPECIAL_COMMAND_ADDR)
		&& (wr.data == gauge_cfg_pkg::FULL_RESET_CODE); // R13 R14
	wire [7:0] alert_pct = level_pct(settings.charge_alert_level); // R10 R11
	wire below = I_SOC_PCT < alert_pct;
	wire alert_hit = I_SOC_VALID && !settings.sleep && below && armed; // R6 R17
	wire flag_clear = settings_wr && !wr.data[gauge_cfg_pkg::FLAG_BIT];
	// a second sample agreeing with the third marks a settled level
	wire pin_settled = pin_sync[1] == pin_sync[2];
	wire pin_rise = pin_settled && pin_sync[2] && !pin_level; // R15

	// ----------------------------------------
	// next settings
	// ----------------------------------------
	always_comb begin
		next_settings = settings;
		if (settings_wr) begin
			next_settings.model_compensation_byte = wr.data[gauge_cfg_pkg::COMP_MSB:gauge_cfg_pkg::COMP_LSB]; // R1
			next_settings.sleep = wr.data[gauge_cfg_pkg::SLEEP_BIT]; // R2 R3
			next_settings.charge_alert_level = wr.data[gauge_cfg_pkg::LEVEL_MSB:gauge_cfg_pkg::LEVEL_LSB]; // R9
		end
		next_settings.dont_care = gauge_cfg_pkg::DONT_CARE_READ; // R5
		// set wins over a clear in the same cycle; sleep never touches the flag
		if (alert_hit)
			next_settings.low_charge_flag = 1'b1; // R6 R19
		else if (flag_clear)
			next_settings.low_charge_flag = 1'b0; // R7
		// a full reset overrides everything written in the same word
		if (full_reset_wr)
			next_settings = gauge_cfg_pkg::SETTINGS_RESET; // R13
	end

	// re-armed by a full reset or by a sample at or above the level taken after the flag is cleared,
	// so a recovery seen while the alert is still pending does not count
	always_comb begin
		next_armed = armed;
		if (alert_hit)
			next_armed = 1'b0;
		else if (I_SOC_VALID && !settings.sleep && !below && !settings.low_charge_flag)
			next_armed = 1'b1; // R17
		if (full_reset_wr)
			next_armed = 1'b1;
	end

	// ----------------------------------------
	// state
	// ----------------------------------------
	always_ff @(posedge I_MCLK or negedge I_RESET_N) begin
		if (!I_RESET_N) begin
			settings <= gauge_cfg_pkg::SETTINGS_RESET; // R4 R8 R12
			armed <= 1'b1;
		end else begin
			settings <= next_settings;
			armed <= next_armed;
		end
	end

	always_ff @(posedge I_MCLK or negedge I_RESET_N) begin
		if (!I_RESET_N) begin
			pin_sync <= 3'h0;
			pin_level <= 1'b0;
		end else begin
			pin_sync <= {pin_sync[1:0], I_FAST_RESTART_PIN};
			if (pin_settled)
				pin_level <= pin_sync[2];
		end
	end

	// ----------------------------------------
	// outputs, all registered
	// ----------------------------------------
	always_ff @(posedge I_MCLK or negedge I_RESET_N) begin
		if (!I_RESET_N) begin
			O_RD_DATA <= 16'h0000;
			O_NO_ACK <= 1'b0;
			O_SLEEP <= 1'b0;
			O_RESTART <= 1'b0;
			O_FULL_RESET <= 1'b0;
			O_COMPENSATION <= gauge_cfg_pkg::COMP_RESET;
			O_LOW_CHARGE_OUT <= 1'b0;
			O_LOW_CHARGE_OE_N <= 1'b1;
		end else begin
			// the command register is write-only and reads as zero
			O_RD_DATA <= (I_RD_ADDR == gauge_cfg_pkg::GAUGE_SETTINGS_ADDR) ? next_settings : 16'h0000;
			O_NO_ACK <= full_reset_wr; // R18
			O_SLEEP <= next_settings.sleep; // R2 R3
			// a full reset also restarts the gauge, as at power-up
			O_RESTART <= pin_rise || full_reset_wr; // R15
			O_FULL_RESET <= full_reset_wr; // R13 R18
			O_COMPENSATION <= next_settings.model_compensation_byte;
			O_LOW_CHARGE_OUT <= 1'b0;
			O_LOW_CHARGE_OE_N <= !next_settings.low_charge_flag; // R16 R19
		end
	end

	// ----------------------------------------
	// assertions
	// ----------------------------------------
	default clocking cb @(posedge I_MCLK); endclocking
	default disable iff (!I_RESET_N);

	a_sleep_on_write: assert property (settings_wr && wr.data[gauge_cfg_pkg::SLEEP_BIT] && !full_reset_wr
		|=> O_SLEEP) else $error("sleep write of one did not enter sleep"); // R2
	a_sleep_off_write: assert property (settings_wr && !wr.data[gauge_cfg_pkg::SLEEP_BIT]
		|=> !O_SLEEP) else $error("sleep write of zero did not leave sleep"); // R3
	a_dont_care_fixed: assert property (settings_wr |=> settings.dont_care == gauge_cfg_pkg::DONT_CARE_READ)
		else $error("don't-care bit took a written value"); // R5
	a_alert_sets_pin: assert property (I_SOC_VALID && !settings.sleep && armed && I_SOC_PCT < level_pct(settings.charge_alert_level)
		&& !full_reset_wr |=> settings.low_charge_flag && !O_LOW_CHARGE_OE_N)
		else $error("low charge did not raise the alert"); // R6
	a_flag_sticky: assert property (settings.low_charge_flag && !(settings_wr && !wr.data[gauge_cfg_pkg::FLAG_BIT])
		&& !full_reset_wr |=> settings.low_charge_flag) else $error("flag cleared without software"); // R7
	a_pin_tracks_flag: assert property (##1 O_LOW_CHARGE_OE_N == !settings.low_charge_flag)
		else $error("alert pin does not follow flag"); // R16
	a_level_decode: assert property (settings.charge_alert_level == gauge_cfg_pkg::LEVEL_RESET |-> alert_pct == 8'h04)
		else $error("level code 1c is not four percent"); // R12
	a_no_realert: assert property (!armed && I_SOC_VALID && !full_reset_wr && !(settings_wr && !wr.data[gauge_cfg_pkg::FLAG_BIT])
		&& !settings.low_charge_flag |=> !settings.low_charge_flag) else $error("alert raised without re-arming"); // R17
	a_full_reset_code: assert property (full_reset_wr |=> O_FULL_RESET && O_NO_ACK && !settings.sleep
		&& settings.charge_alert_level == gauge_cfg_pkg::LEVEL_RESET) else $error("reset code did not reset"); // R13
	a_sleep_keeps_flag: assert property (settings.low_charge_flag && settings_wr && wr.data[gauge_cfg_pkg::SLEEP_BIT]
		&& wr.data[gauge_cfg_pkg::FLAG_BIT] |=> settings.low_charge_flag) else $error("sleep cleared the alert"); // R19
	a_restart_edge: assert property ($rose(pin_level) |-> O_RESTART) else $error("restart edge missed"); // R15

	// ----------------------------------------
	// register map and read path
	// ----------------------------------------
	a_comp_write: assert property (settings_wr // R1
		|=> O_COMPENSATION == $past(wr.data[gauge_cfg_pkg::COMP_MSB:gauge_cfg_pkg::COMP_LSB]))
		else $error("compensation byte not taken from the written word");
	a_level_write: assert property (settings_wr // R9
		|=> settings.charge_alert_level == $past(wr.data[gauge_cfg_pkg::LEVEL_MSB:gauge_cfg_pkg::LEVEL_LSB]))
		else $error("alert level not taken from the written word");
	a_read_settings: assert property (I_RD_ADDR == gauge_cfg_pkg::GAUGE_SETTINGS_ADDR // R1
		|=> O_RD_DATA == settings)
		else $error("settings read does not show the settings word");
	a_read_other: assert property (I_RD_ADDR != gauge_cfg_pkg::GAUGE_SETTINGS_ADDR // R1
		|=> O_RD_DATA == 16'h0000)
		else $error("unmapped read is not zero");
	a_dont_care_read: assert property ( // R5
		O_RD_DATA[gauge_cfg_pkg::DONT_CARE_BIT] == gauge_cfg_pkg::DONT_CARE_READ)
		else $error("don't-care bit reads a wrong value");
	a_dont_care_reg: assert property ( // R5
		settings.dont_care == gauge_cfg_pkg::DONT_CARE_READ)
		else $error("don't-care bit holds a wrong value");
	a_comp_matches: assert property ( // R1
		O_COMPENSATION == settings.model_compensation_byte)
		else $error("compensation output differs from the register");

	// ----------------------------------------
	// sleep control
	// ----------------------------------------
	a_sleep_matches: assert property ( // R2
		O_SLEEP == settings.sleep)
		else $error("sleep output differs from the register");
	a_sleep_holds: assert property (!settings_wr && !full_reset_wr // R2
		|=> O_SLEEP == $past(O_SLEEP))
		else $error("sleep changed without a write");
	a_sleep_no_alert: assert property (settings.sleep && !settings.low_charge_flag // R2
		|=> !settings.low_charge_flag)
		else $error("alert raised while asleep");
	a_sleep_reset_val: assert property (full_reset_wr // R4
		|=> !O_SLEEP)
		else $error("full reset left the gauge asleep");

	// ----------------------------------------
	// alert flag and pin
	// ----------------------------------------
	a_flag_reset_val: assert property (full_reset_wr // R8
		|=> !settings.low_charge_flag)
		else $error("full reset left the flag set");
	a_flag_clear: assert property (flag_clear && !alert_hit // R7
		|=> !settings.low_charge_flag)
		else $error("software clear of the flag ignored");
	a_flag_no_write_set: assert property (settings_wr && wr.data[gauge_cfg_pkg::FLAG_BIT] // R7
		&& !settings.low_charge_flag && !alert_hit |=> !settings.low_charge_flag)
		else $error("writing one set the flag");
	a_set_wins: assert property (alert_hit && flag_clear // R6
		|=> settings.low_charge_flag)
		else $error("clear won over a new alert");
	a_flag_only_low: assert property (!settings.low_charge_flag && !alert_hit // R6
		|=> !settings.low_charge_flag)
		else $error("flag set without low charge");
	a_pin_data_low: assert property ( // R16
		O_LOW_CHARGE_OUT == 1'b0)
		else $error("alert pin data is not low");
	a_pin_held: assert property (!O_LOW_CHARGE_OE_N && !flag_clear && !full_reset_wr // R16
		|=> !O_LOW_CHARGE_OE_N)
		else $error("alert pin released without a clear");
	a_disarm_on_hit: assert property (alert_hit // R17
		|=> !armed)
		else $error("alert did not disarm");
	a_rearm_needs_clear: assert property (settings.low_charge_flag && !armed && !full_reset_wr // R17
		|=> !armed)
		else $error("re-armed while the flag is pending");
	a_rearm_on_rise: assert property (!armed && I_SOC_VALID && !settings.sleep && !below // R17
		&& !settings.low_charge_flag |=> armed)
		else $error("recovered charge did not re-arm");

	// ----------------------------------------
	// level decode
	// ----------------------------------------
	a_level_top: assert property (settings.charge_alert_level == 5'h00 // R10
		|-> alert_pct == {2'b00, gauge_cfg_pkg::LEVEL_TOP_PCT})
		else $error("level code zero is not the top percentage");
	a_level_bottom: assert property (settings.charge_alert_level == 5'h1f // R11
		|-> alert_pct == 8'h01)
		else $error("level code all ones is not one percent");
	a_level_range: assert property ( // R9
		alert_pct >= 8'h01 && alert_pct <= 8'h20)
		else $error("alert percentage out of range");
	a_level_reset_val: assert property (full_reset_wr // R12
		|=> settings.charge_alert_level == gauge_cfg_pkg::LEVEL_RESET)
		else $error("full reset did not restore the level");

	// ----------------------------------------
	// command register and restart
	// ----------------------------------------
	a_reserved_ignored: assert property (wr.en && wr.addr == gauge_cfg_pkg::SPECIAL_COMMAND_ADDR // R13
		&& !full_reset_wr |=> !O_FULL_RESET && !O_NO_ACK)
		else $error("reserved command acted");
	a_reset_restarts: assert property (full_reset_wr // R13
		|=> O_RESTART)
		else $error("full reset did not restart the gauge");
	a_no_ack_pulse: assert property (O_NO_ACK // R18
		|-> O_FULL_RESET)
		else $error("ack withheld without a full reset");
	a_full_reset_pulse: assert property (!full_reset_wr // R18
		|=> !O_FULL_RESET)
		else $error("full reset without the reset code");
	a_full_reset_comp: assert property (full_reset_wr // R13
		|=> O_COMPENSATION == gauge_cfg_pkg::COMP_RESET && O_LOW_CHARGE_OE_N)
		else $error("full reset left compensation or pin");
	a_restart_cause: assert property (O_RESTART // R15
		|-> $past(pin_rise || full_reset_wr))
		else $error("restart without a cause");
	a_pin_level_settled: assert property ($changed(pin_level) // R15
		|-> $past(pin_sync[1] == pin_sync[2]))
		else $error("restart level taken before it settled");

	c_alert_then_clear: cover property (settings.low_charge_flag ##[1:20] !settings.low_charge_flag);
	c_full_reset: cover property (O_FULL_RESET);
	c_sleep_cycle: cover property (O_SLEEP ##[1:20] !O_SLEEP);
	c_pin_restart: cover property (O_RESTART && !O_FULL_RESET);
	c_rearm: cover property (!armed ##1 armed);

endmodule

// ==== verif/gauge_host_model.sv ====
// host-side model: hands the block whole 16-bit register words, one strobe per word
// assumes its output feeds the word port of the gauge configuration block
`timescale 1ns/1ns
module gauge_host_model (
	// clock
	input wire logic i_clk,
	// word write
	output gauge_cfg_pkg::reg_write_t o_wr
);
	initial o_wr = '0;
	// released lines show the inverse, so a stale word can never pass for a new one
	task automatic put(input logic [7:0] a, input logic [15:0] d);
		@(negedge i_clk) o_wr = '{en: 1'b1, addr: a, data: d};
		@(negedge i_clk) o_wr = '{en: 1'b0, addr: ~a, data: ~d};
	endtask
endmodule

// ==== verif/gauge_config_alert_control_bench.sv ====
// self-checking bench for the gauge configuration, alert and command logic
// assumes the host model for word writes; other inputs change on falling edges
`timescale 1ns/1ns
module gauge_config_alert_control_bench;
	typedef struct packed {logic [15:0] rd; logic [7:0] comp; logic [4:0] f;} snap_t;
	logic clk = 1'b0, rst_n = 1'b0, soc_v = 1'b0, pin = 1'b0;
	logic [7:0] rd_a = 8'h0c, pct = 8'h00, comp;
	logic [15:0] rd;
	logic sleep, restart, full, no_ack, lc_out, oe_n;
	logic [4:0] lvl;
	logic [31:0] seed = 32'hb7f8;
	int n_mismatch = 0, checks = 0;
	snap_t q[$];
	event look;
	gauge_cfg_pkg::reg_write_t wr;
	always #10 clk = ~clk;
	gauge_host_model host_u (.i_clk(clk), .o_wr(wr));
	gauge_config_alert_control dut_u (.I_MCLK(clk), .I_RESET_N(rst_n), .I_WR_EN(wr.en), .I_WR_ADDR(wr.addr),
		.I_WR_DATA(wr.data), .I_RD_ADDR(rd_a), .O_RD_DATA(rd), .O_NO_ACK(no_ack), .I_SOC_VALID(soc_v),
		.I_SOC_PCT(pct), .O_SLEEP(sleep), .O_RESTART(restart), .O_FULL_RESET(full), .O_COMPENSATION(comp),
		.I_FAST_RESTART_PIN(pin), .O_LOW_CHARGE_OUT(lc_out), .O_LOW_CHARGE_OE_N(oe_n));
	// ----------------------------------------
	// helpers
	// ----------------------------------------
	function automatic logic [31:0] xs(input logic [31:0] s);
		s ^= s << 13;
		s ^= s >> 17;
		s ^= s << 5;
		return s;
	endfunction
	// f = {alert pin enable_n, sleep, full reset, no ack, restart}
	function automatic snap_t e(input logic [15:0] r, input logic [7:0] c, input logic [4:0] f);
		return {r, c, f};
	endfunction
	task automatic tick(input int n);
		repeat (n) @(negedge clk);
	endtask
	task automatic soc(input logic [7:0] p);
		@(negedge clk) begin
			soc_v = 1'b1;
			pct = p;
		end
		@(negedge clk) soc_v = 1'b0;
	endtask
	task automatic expect_now(input snap_t x);
		q.push_back(x);
		-> look;
		#1;
	endtask
	task automatic cmp_snap(input snap_t x, input snap_t a);
		checks++;
		if (a !== x) begin
			n_mismatch++;
			$display("wrong value at %0t: expected %h got %h", $time, x, a);
		end
	endtask
	task automatic end_sim();
		$display("mismatches %0d checks %0d", n_mismatch, checks);
		if (n_mismatch == 0 && checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	always @(look) cmp_snap(q.pop_front(), {rd, comp, oe_n, sleep, full, no_ack, restart});
	initial begin
		#100000;
		n_mismatch++;
		end_sim();
	end
	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	initial begin
		tick(10);
		rst_n = 1'b1;
		tick(1);
		expect_now(e(16'h971c, 8'h97, 5'b10000));
		host_u.put(8'h0c, 16'h17ff);
		expect_now(e(16'h179f, 8'h17, 5'b11000));
		soc(8'h00);
		expect_now(e(16'h179f, 8'h17, 5'b11000));
		host_u.put(8'h0c, 16'h2a1c);
		expect_now(e(16'h2a1c, 8'h2a, 5'b10000));
		repeat (4) begin
			seed = xs(seed);
			lvl = seed[4:0];
			host_u.put(8'h0c, {8'h2a, 3'h0, lvl});
			soc(8'h20 - {3'h0, lvl});
			expect_now(e({8'h2a, 3'h0, lvl}, 8'h2a, 5'b10000));
			soc(8'h1f - {3'h0, lvl});
			expect_now(e({8'h2a, 3'h1, lvl}, 8'h2a, 5'b00000));
			soc(8'h20 - {3'h0, lvl});
			expect_now(e({8'h2a, 3'h1, lvl}, 8'h2a, 5'b00000));
			host_u.put(8'h0c, {8'h2a, 3'h0, lvl});
			soc(8'h1f - {3'h0, lvl});
			expect_now(e({8'h2a, 3'h0, lvl}, 8'h2a, 5'b10000));
		end
		soc(8'h20);
		soc(8'h00);
		host_u.put(8'h0c, {8'h2a, 3'h5, lvl});
		expect_now(e({8'h2a, 3'h5, lvl}, 8'h2a, 5'b01000));
		@(negedge clk) rd_a = 8'h00;
		// deliberately reserved command value, must change nothing
		host_u.put(8'hfe, 16'h0055);
		expect_now(e(16'h0000, 8'h2a, 5'b01000));
		host_u.put(8'hfe, 16'h0054);
		expect_now(e(16'h0000, 8'h97, 5'b10111));
		@(negedge clk) rd_a = 8'h0c;
		tick(1);
		expect_now(e(16'h971c, 8'h97, 5'b10000));
		@(negedge clk) pin = 1'b1;
		for (int i = 0; i < 10 && restart !== 1'b1; i++)
			tick(1);
		expect_now(e(16'h971c, 8'h97, 5'b10001));
		tick(1);
		expect_now(e(16'h971c, 8'h97, 5'b10000));
		end_sim();
	end
endmodule
